// ===== logic/acd_pkg.sv
package acd_pkg;
   // register indices; byte address is four times the index
   localparam logic [7:0] IDX_PRI_LOW = 8'h3c;
   localparam logic [7:0] IDX_SEC_LOW = 8'h3d;
   localparam logic [7:0] IDX_ANALOG = 8'h3e;
   localparam logic [7:0] IDX_CORE_EN = 8'h44;
   localparam logic [7:0] IDX_PORT_EN = 8'h45;
   localparam logic [7:0] IDX_OUT_SRC = 8'h46;
   localparam logic [7:0] IDX_OUT_DIV = 8'h47;
   localparam logic [7:0] IDX_HIGH_BITS = 8'h3b;
   localparam logic [7:0] IDX_AUTO_CTRL = 8'h4f;
   localparam logic [7:0] IDX_STATUS = 8'h4e;
   // reset values
   localparam logic [7:0] RST_PRI_LOW = 8'h01;
   localparam logic [7:0] RST_SEC_LOW = 8'h01;
   localparam logic [7:0] RST_ANALOG = 8'h01;
   localparam logic [7:0] RST_CORE_EN = 8'h00;
   localparam logic [7:0] RST_PORT_EN = 8'h00;
   localparam logic [7:0] RST_OUT_SRC = 8'h00;
   localparam logic [7:0] RST_OUT_DIV = 8'h01;
   localparam logic [7:0] RST_HIGH_BITS = 8'h00;
   localparam logic [7:0] RST_AUTO_CTRL = 8'h00;
   // writable bit masks; read-only reserved bits stay zero
   localparam logic [7:0] MSK_ANALOG = 8'h3f;
   localparam logic [7:0] MSK_CORE_EN = 8'h07;
   localparam logic [7:0] MSK_OUT_SRC = 8'h07;
   localparam logic [7:0] MSK_HIGH_BITS = 8'h06;
   localparam logic [7:0] MSK_AUTO_CTRL = 8'h01;
   localparam logic [7:0] MSK_FULL = 8'hff;
   // field positions
   localparam int POS_N_EN = 2;
   localparam int POS_M_EN = 1;
   localparam int POS_PDM_EN = 0;
   localparam int POS_ADC_MOD_EN = 6;
   localparam int POS_DAC_MOD_EN = 4;
   localparam int POS_PRI_BCLK_EN = 3;
   localparam int POS_SEC_BCLK_EN = 2;
   localparam int POS_PRI_FRAME_EN = 1;
   localparam int POS_SEC_FRAME_EN = 0;
   localparam int POS_PRI_HIGH = 2;
   localparam int POS_SEC_HIGH = 1;
   localparam int POS_OUT_DIV_EN = 7;
   localparam int POS_AUTO_EN = 0;
   // divider ratio encodings
   localparam logic [9:0] BCLK_ZERO_RATIO = 10'h200;
   localparam logic [8:0] BCLK_ODD_CODE = 9'h03f;
   localparam logic [9:0] BCLK_ODD_RATIO = 10'h1ff;
   localparam logic [9:0] ANA_ZERO_RATIO = 10'h040;
   localparam logic [9:0] OUT_ZERO_RATIO = 10'h080;
   localparam logic [2:0] SRC_LAST_CODE = 3'h5;
   // divider slots
   localparam int NUM_DIV = 4;
   localparam int DIV_PRI = 0;
   localparam int DIV_SEC = 1;
   localparam int DIV_ANA = 2;
   localparam int DIV_OUT = 3;

   // bus slave states
   typedef enum logic {BUS_IDLE, BUS_ACK} acd_bus_e;

   // stage enables driven to the rest of the clock tree
   typedef struct packed {
      logic n_stage_enable;
      logic m_stage_enable;
      logic pulse_density_divider_enable;
      logic adc_modulator_divider_enable;
      logic dac_modulator_divider_enable;
      logic primary_frame_divider_enable;
      logic secondary_frame_divider_enable;
   } acd_stage_en_s;
endpackage

// ===== logic/acd_top.sv
// Our own choice: the Wishbone interface to the registers.
module acd_top #(
   parameter logic [9:0] AUTO_BCLK_RATIO = 10'h040,
   parameter logic [9:0] AUTO_ANA_RATIO = 10'h008
) (
   input wire logic CORE_CLK,
   input wire logic RESET,
   input wire logic WB_CYC_I,
   input wire logic WB_STB_I,
   input wire logic WB_WE_I,
   input wire logic [9:0] WB_ADR_I,
   input wire logic [3:0] WB_SEL_I,
   input wire logic [31:0] WB_DAT_I,
   output logic [31:0] WB_DAT_O,
   output logic WB_ACK_O,
   input wire logic [5:0] CLK_SOURCES,
   output logic PRIMARY_BCLK,
   output logic SECONDARY_BCLK,
   output logic ANALOG_CLK,
   output logic OUTPUT_CLK,
   output acd_pkg::acd_stage_en_s STAGE_ENABLES
);
   import acd_pkg::*;

   // configuration registers
   logic [7:0] pri_low_q, pri_low_d;
   logic [7:0] sec_low_q, sec_low_d;
   logic [7:0] analog_q, analog_d;
   logic [7:0] core_en_q, core_en_d;
   logic [7:0] port_en_q, port_en_d;
   logic [7:0] out_src_q, out_src_d;
   logic [7:0] out_div_q, out_div_d;
   logic [7:0] high_q, high_d;
   logic [7:0] auto_q, auto_d;
   // bus slave state
   acd_bus_e bus_q, bus_d;
   logic [31:0] rdat_q, rdat_d;
   acd_stage_en_s stage_q, stage_d;
   // divider state, one slot per divider
   logic [9:0] cnt_q [NUM_DIV];
   logic [9:0] cnt_d [NUM_DIV];
   logic run_q [NUM_DIV];
   logic run_d [NUM_DIV];
   logic out_q [NUM_DIV];
   logic out_d [NUM_DIV];
   logic [9:0] ratio [NUM_DIV];
   logic en_req [NUM_DIV];
   logic advance [NUM_DIV];
   // selected output source, previous sample for edge finding
   logic src_prev_q, src_prev_d;
   logic src_now;
   logic [7:0] index;
   logic req;
   logic wr_stb;

   assign index = WB_ADR_I[9:2];
   assign req = WB_CYC_I && WB_STB_I;
   // a write lands on the edge that the master sees ack
   assign wr_stb = req && WB_WE_I && (bus_q == BUS_ACK) && WB_SEL_I[0];

   // masked store of one byte, reserved read-only bits forced low
   function automatic logic [7:0] store(input logic [7:0] old,
                                        input logic [7:0] msk,
                                        input logic hit);
      store = hit ? (WB_DAT_I[7:0] & msk) : old;
   endfunction

   // bclk ratio from the joined nine-bit code
   function automatic logic [9:0] bclk_ratio(input logic hi,
                                             input logic [7:0] lo);
      logic [8:0] code;
      code = {hi, lo};
      if (code == 9'h000) begin
         bclk_ratio = BCLK_ZERO_RATIO;
      end else if (code == BCLK_ODD_CODE) begin
         bclk_ratio = BCLK_ODD_RATIO;
      end else begin
         bclk_ratio = {1'b0, code};
      end
   endfunction

   // register write decode
   always_comb begin
      pri_low_d = store(pri_low_q, MSK_FULL,
                        wr_stb && index == IDX_PRI_LOW);
      sec_low_d = store(sec_low_q, MSK_FULL,
                        wr_stb && index == IDX_SEC_LOW);
      analog_d = store(analog_q, MSK_ANALOG,
                       wr_stb && index == IDX_ANALOG);
      core_en_d = store(core_en_q, MSK_CORE_EN,
                        wr_stb && index == IDX_CORE_EN);
      port_en_d = store(port_en_q, MSK_FULL,
                        wr_stb && index == IDX_PORT_EN);
      out_src_d = store(out_src_q, MSK_OUT_SRC,
                        wr_stb && index == IDX_OUT_SRC);
      out_div_d = store(out_div_q, MSK_FULL,
                        wr_stb && index == IDX_OUT_DIV);
      high_d = store(high_q, MSK_HIGH_BITS,
                     wr_stb && index == IDX_HIGH_BITS);
      auto_d = store(auto_q, MSK_AUTO_CTRL,
                     wr_stb && index == IDX_AUTO_CTRL);
   end

   // configuration registers
   always_ff @(posedge CORE_CLK or posedge RESET) begin
      if (RESET) begin
         pri_low_q <= RST_PRI_LOW;
         sec_low_q <= RST_SEC_LOW;
         analog_q <= RST_ANALOG;
         core_en_q <= RST_CORE_EN;
         port_en_q <= RST_PORT_EN;
         out_src_q <= RST_OUT_SRC;
         out_div_q <= RST_OUT_DIV;
         high_q <= RST_HIGH_BITS;
         auto_q <= RST_AUTO_CTRL;
      end else begin
         pri_low_q <= pri_low_d;
         sec_low_q <= sec_low_d;
         analog_q <= analog_d;
         core_en_q <= core_en_d;
         port_en_q <= port_en_d;
         out_src_q <= out_src_d;
         out_div_q <= out_div_d;
         high_q <= high_d;
         auto_q <= auto_d;
      end
   end

   // bus answer: ack one cycle after the request, read data with it
   always_comb begin
      bus_d = BUS_IDLE;
      rdat_d = rdat_q;
      unique case (bus_q)
         BUS_IDLE: begin
            // wait for a fresh request
            if (req) begin
               bus_d = BUS_ACK;
               rdat_d = 32'h0000_0000;
               unique case (index)
                  IDX_PRI_LOW: rdat_d[7:0] = pri_low_q;
                  IDX_SEC_LOW: rdat_d[7:0] = sec_low_q;
                  IDX_ANALOG: rdat_d[7:0] = analog_q;
                  IDX_CORE_EN: rdat_d[7:0] = core_en_q;
                  IDX_PORT_EN: rdat_d[7:0] = port_en_q;
                  IDX_OUT_SRC: rdat_d[7:0] = out_src_q;
                  IDX_OUT_DIV: rdat_d[7:0] = out_div_q;
                  IDX_HIGH_BITS: rdat_d[7:0] = high_q;
                  IDX_AUTO_CTRL: rdat_d[7:0] = auto_q;
                  // live view of which dividers are running
                  IDX_STATUS: rdat_d[3:0] = {run_q[DIV_OUT],
                                             run_q[DIV_ANA],
                                             run_q[DIV_SEC],
                                             run_q[DIV_PRI]};
                  // unmapped: acked, reads zero, writes dropped
                  default: rdat_d = 32'h0000_0000;
               endcase
            end
         end
         BUS_ACK: begin
            // ack drops after one cycle, forcing an idle gap
            bus_d = BUS_IDLE;
         end
      endcase
   end

   // bus registers
   always_ff @(posedge CORE_CLK or posedge RESET) begin
      if (RESET) begin
         bus_q <= BUS_IDLE;
         rdat_q <= 32'h0000_0000;
      end else begin
         bus_q <= bus_d;
         rdat_q <= rdat_d;
      end
   end

   assign WB_ACK_O = (bus_q == BUS_ACK);
   assign WB_DAT_O = rdat_q;

   // stage enables toward the rest of the clock tree
   always_comb begin
      stage_d.n_stage_enable = core_en_q[POS_N_EN];
      stage_d.m_stage_enable = core_en_q[POS_M_EN];
      stage_d.pulse_density_divider_enable = core_en_q[POS_PDM_EN];
      stage_d.adc_modulator_divider_enable = port_en_q[POS_ADC_MOD_EN];
      stage_d.dac_modulator_divider_enable = port_en_q[POS_DAC_MOD_EN];
      stage_d.primary_frame_divider_enable = port_en_q[POS_PRI_FRAME_EN];
      stage_d.secondary_frame_divider_enable =
         port_en_q[POS_SEC_FRAME_EN];
   end

   // stage enable flops, one cycle behind the register
   always_ff @(posedge CORE_CLK or posedge RESET) begin
      if (RESET) begin
         stage_q <= '0;
      end else begin
         stage_q <= stage_d;
      end
   end

   assign STAGE_ENABLES = stage_q;

   // ratios and enables per divider
   always_comb begin
      // high bit joined above low byte
      ratio[DIV_PRI] = bclk_ratio(high_q[POS_PRI_HIGH], pri_low_q);
      ratio[DIV_SEC] = bclk_ratio(high_q[POS_SEC_HIGH], sec_low_q);
      ratio[DIV_ANA] = (analog_q[5:0] == 6'h00) ? ANA_ZERO_RATIO
                                                : {4'h0, analog_q[5:0]};
      if (auto_q[POS_AUTO_EN]) begin
         ratio[DIV_PRI] = AUTO_BCLK_RATIO;
         ratio[DIV_SEC] = AUTO_BCLK_RATIO;
         ratio[DIV_ANA] = AUTO_ANA_RATIO;
      end
      ratio[DIV_OUT] = (out_div_q[6:0] == 7'h00) ? OUT_ZERO_RATIO
                                                 : {3'h0, out_div_q[6:0]};
      en_req[DIV_PRI] = port_en_q[POS_PRI_BCLK_EN];
      en_req[DIV_SEC] = port_en_q[POS_SEC_BCLK_EN];
      // analog clock follows the M stage
      en_req[DIV_ANA] = core_en_q[POS_M_EN];
      en_req[DIV_OUT] = out_div_q[POS_OUT_DIV_EN];
   end

   // output clock source pick; reserved codes give no source
   always_comb begin
      if (out_src_q[2:0] <= SRC_LAST_CODE) begin
         src_now = CLK_SOURCES[out_src_q[2:0]];
      end else begin
         src_now = 1'b0;
      end
      src_prev_d = src_now;
   end

   // previous source level
   always_ff @(posedge CORE_CLK or posedge RESET) begin
      if (RESET) begin
         src_prev_q <= 1'b0;
      end else begin
         src_prev_q <= src_prev_d;
      end
   end

   // the output divider counts source rising edges, others core clocks
   assign advance[DIV_PRI] = 1'b1;
   assign advance[DIV_SEC] = 1'b1;
   assign advance[DIV_ANA] = 1'b1;
   assign advance[DIV_OUT] = src_now && !src_prev_q;

   // one counter per divider; high for the first half of each period
   generate
      for (genvar i = 0; i < NUM_DIV; i++) begin : g_div
         always_comb begin
            cnt_d[i] = cnt_q[i];
            run_d[i] = run_q[i];
            if (advance[i]) begin
               if (!run_q[i] || cnt_q[i] >= ratio[i] - 10'h001) begin
                  cnt_d[i] = 10'h000;
                  run_d[i] = en_req[i];
               end else begin
                  cnt_d[i] = cnt_q[i] + 10'h001;
               end
            end
            out_d[i] = run_d[i] &&
                       (cnt_d[i] < ((ratio[i] + 10'h001) >> 1));
         end

         // divider flops; a ratio drop mid-period wraps early
         always_ff @(posedge CORE_CLK or posedge RESET) begin
            if (RESET) begin
               cnt_q[i] <= 10'h000;
               run_q[i] <= 1'b0;
               out_q[i] <= 1'b0;
            end else begin
               cnt_q[i] <= cnt_d[i];
               run_q[i] <= run_d[i];
               out_q[i] <= out_d[i];
            end
         end
      end
   endgenerate

   assign PRIMARY_BCLK = out_q[DIV_PRI];
   assign SECONDARY_BCLK = out_q[DIV_SEC];
   assign ANALOG_CLK = out_q[DIV_ANA];
   assign OUTPUT_CLK = out_q[DIV_OUT];
endmodule

// ===== tb/acd_top_asserts.sv
module acd_top_asserts (
   input wire logic CORE_CLK,
   input wire logic RESET,
   input wire logic WB_CYC_I,
   input wire logic WB_STB_I,
   input wire logic WB_WE_I,
   input wire logic [9:0] WB_ADR_I,
   input wire logic [31:0] WB_DAT_O,
   input wire logic WB_ACK_O,
   input wire logic PRIMARY_BCLK,
   input wire logic OUTPUT_CLK,
   input wire acd_pkg::acd_stage_en_s STAGE_ENABLES
);
   import acd_pkg::*;
   // one clock domain, so the defaults serve every property
   default clocking @(posedge CORE_CLK); endclocking
   default disable iff (RESET);
   // the slave answers exactly one cycle after taking a request
   a_ack_pulse: assert property (WB_ACK_O |=> !WB_ACK_O)
      else $error("ack held longer than one cycle");
   a_ack_answer: assert property (WB_CYC_I && WB_STB_I && !WB_ACK_O
      |=> WB_ACK_O) else $error("request not answered next cycle");
   a_ack_cause: assert property (WB_ACK_O |-> $past(WB_CYC_I && WB_STB_I))
      else $error("ack without a request");
   a_high_zero: assert property (
      WB_ACK_O |-> WB_DAT_O[31:8] == 24'h00_0000)
      else $error("read data upper bits not zero");
   a_resv_zero: assert property (
      WB_ACK_O && $past(!WB_WE_I && (WB_ADR_I[9:2] == IDX_CORE_EN ||
      WB_ADR_I[9:2] == IDX_OUT_SRC)) |-> WB_DAT_O[7:3] == 5'h00)
      else $error("reserved bits read nonzero");
   a_ana_zero: assert property (
      WB_ACK_O && $past(!WB_WE_I && WB_ADR_I[9:2] == IDX_ANALOG)
      |-> WB_DAT_O[7:6] == 2'h0) else $error("analog top bits nonzero");
   a_unmap_zero: assert property (
      WB_ACK_O && $past(!WB_WE_I && WB_ADR_I[9:2] == 8'h00)
      |-> WB_DAT_O == 32'h0000_0000) else $error("unmapped read nonzero");
   a_reset_quiet: assert property (
      $past(RESET) |-> STAGE_ENABLES == 7'h00 && !PRIMARY_BCLK &&
      !OUTPUT_CLK) else $error("outputs active after reset");
   // a stage enable moves only two edges after a write answer
   a_stage_hold: assert property (
      $changed(STAGE_ENABLES) |-> $past(WB_ACK_O, 2))
      else $error("stage enable changed without a write");
   c_write: cover property (WB_ACK_O && $past(WB_WE_I));
   c_read: cover property (WB_ACK_O && $past(!WB_WE_I));
   c_stage: cover property ($changed(STAGE_ENABLES));
endmodule
bind acd_top acd_top_asserts u_chk (.CORE_CLK, .RESET, .WB_CYC_I,
   .WB_STB_I, .WB_WE_I, .WB_ADR_I, .WB_DAT_O, .WB_ACK_O, .PRIMARY_BCLK,
   .OUTPUT_CLK, .STAGE_ENABLES);

// ===== tb/test_acd_top.sv
module test_acd_top;
   timeunit 1ns;
   timeprecision 100ps;
   import acd_pkg::*;
   logic core_clk = 1'b0;
   logic reset = 1'b1;
   logic cyc = 1'b0;
   logic stb = 1'b0;
   logic we = 1'b0;
   logic [9:0] adr = 10'h000;
   logic [3:0] sel = 4'hf;
   logic [31:0] dat_i = 32'h0000_0000;
   logic [31:0] dat_o;
   logic ack, pbclk, sbclk, aclk, oclk;
   logic [5:0] srcs = 6'h00;
   acd_stage_en_s stg;
   int fails = 0;
   int checks_done = 0;
   // divider table: output, register, code, expected period
   int tw[12] = '{0, 0, 0, 0, 0, 0, 1, 1, 2, 2, 0, 2};
   logic [7:0] ti[12] = '{IDX_PRI_LOW, IDX_PRI_LOW, IDX_PRI_LOW,
      IDX_PRI_LOW, IDX_PRI_LOW, IDX_HIGH_BITS, IDX_SEC_LOW, IDX_HIGH_BITS,
      IDX_ANALOG, IDX_ANALOG, IDX_AUTO_CTRL, IDX_AUTO_CTRL};
   logic [7:0] tc[12] = '{8'h00, 8'h02, 8'h25, 8'h3f, 8'h05, 8'h04,
      8'h03, 8'h02, 8'h00, 8'h05, 8'h01, 8'h01};
   int te[12] = '{512, 2, 37, 511, 5, 261, 3, 259, 64, 5, 64, 8};
   // 40 MHz core clock
   always #12.5 core_clk = ~core_clk;
   // each source bit runs at half the rate of the one below it
   always @(posedge core_clk) srcs <= srcs + 6'h01;
   acd_top #(.AUTO_BCLK_RATIO(10'h040), .AUTO_ANA_RATIO(10'h008)) DUT (
      .CORE_CLK(core_clk), .RESET(reset), .WB_CYC_I(cyc), .WB_STB_I(stb),
      .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(dat_i),
      .WB_DAT_O(dat_o), .WB_ACK_O(ack), .CLK_SOURCES(srcs),
      .PRIMARY_BCLK(pbclk), .SECONDARY_BCLK(sbclk), .ANALOG_CLK(aclk),
      .OUTPUT_CLK(oclk), .STAGE_ENABLES(stg));
   task report_and_stop;
      $display("checks %0d fails %0d", checks_done, fails);
      if (fails == 0 && checks_done > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   // compares any value, four-state exact
   task chk(input logic [31:0] got, input logic [31:0] exp, input string m);
      checks_done++;
      if (got !== exp) begin
         fails++;
         $display("CHECK FAILED %0t %s", $time, m);
      end
   endtask
   // one classic cycle; holds everything until ack is sampled
   task wb(input logic w, input logic [7:0] i, input logic [7:0] d,
      output logic [7:0] r);
      int n;
      @(posedge core_clk);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= {i, 2'b00};
      dat_i <= {24'h00_0000, d};
      n = 0;
      do begin
         @(posedge core_clk);
         n++;
      end while (ack !== 1'b1 && n < 20);
      // a missing answer would hang the bus, so stop here
      if (n >= 20) begin
         fails++;
         report_and_stop;
      end
      r = dat_o[7:0];
      cyc <= 1'b0;
      stb <= 1'b0;
   endtask
   task wr(input logic [7:0] i, input logic [7:0] d);
      logic [7:0] r;
      wb(1'b1, i, d, r);
   endtask
   task rdc(input logic [7:0] i, input logic [7:0] e);
      logic [7:0] r;
      wb(1'b0, i, 8'h00, r);
      chk({24'h00_0000, r}, {24'h00_0000, e}, "register read");
   endtask
   function logic clk_of(int w);
      return w == 0 ? pbclk : w == 1 ? sbclk : w == 2 ? aclk : oclk;
   endfunction
   // period between 2nd and 3rd rise; first may be a ratio change
   task per(input int w, input int lim, output int p, output int k);
      int n, s;
      logic pv;
      p = 0;
      k = 0;
      n = 0;
      s = 0;
      pv = clk_of(w);
      while (k < 3 && n < lim) begin
         @(negedge core_clk);
         n++;
         if (clk_of(w) === 1'b1 && pv === 1'b0) begin
            k++;
            if (k == 2) s = n;
            if (k == 3) p = n - s;
         end
         pv = clk_of(w);
      end
   endtask
   task s_resets;
      rdc(IDX_PRI_LOW, RST_PRI_LOW);
      rdc(IDX_SEC_LOW, RST_SEC_LOW);
      rdc(IDX_ANALOG, RST_ANALOG);
      rdc(IDX_CORE_EN, RST_CORE_EN);
      rdc(IDX_PORT_EN, RST_PORT_EN);
      rdc(IDX_OUT_SRC, RST_OUT_SRC);
      rdc(IDX_OUT_DIV, RST_OUT_DIV);
      chk(32'(stg), 32'h0000_0000, "stage enables after reset");
   endtask
   task s_masks;
      // reserved bits are written only with their reset value of zero
      wr(IDX_ANALOG, 8'h3f);
      wr(IDX_CORE_EN, 8'h07);
      wr(IDX_OUT_SRC, 8'h07);
      wr(IDX_PORT_EN, 8'h5f);
      wr(8'h00, 8'hff);
      rdc(IDX_ANALOG, 8'h3f);
      rdc(IDX_CORE_EN, 8'h07);
      rdc(IDX_OUT_SRC, 8'h07);
      rdc(IDX_PORT_EN, 8'h5f);
      rdc(8'h00, 8'h00);
      chk(32'(stg), 32'h0000_007f, "all stages on");
   endtask
   task s_stage;
      logic [7:0] c[7] = '{8'h04, 8'h02, 8'h01, 8'h00, 8'h00, 8'h00, 8'h00};
      logic [7:0] p[7] = '{8'h00, 8'h08, 8'h04, 8'h40, 8'h10, 8'h02, 8'h01};
      for (int i = 0; i < 7; i++) begin
         wr(IDX_CORE_EN, c[i]);
         wr(IDX_PORT_EN, p[i]);
         repeat (3) @(posedge core_clk);
         chk(32'(stg), 32'h40 >> i, "stage bit");
      end
   endtask
   task s_bclk;
      int p, k;
      wr(IDX_CORE_EN, 8'h02);
      wr(IDX_PORT_EN, 8'h0c);
      for (int i = 0; i < 12; i++) begin
         wr(ti[i], tc[i]);
         per(tw[i], 2000, p, k);
         chk(p, te[i], "divider period");
      end
      // primary, secondary and analog running; output divider stopped
      rdc(IDX_STATUS, 8'h07);
      wr(IDX_AUTO_CTRL, 8'h00);
      wr(IDX_PORT_EN, 8'h00);
      repeat (20) @(posedge core_clk);
      per(0, 1200, p, k);
      chk(k, 0, "stopped clock rose");
      chk({31'h0, pbclk}, 32'h0, "stopped clock high");
      // both port dividers have wrapped and stopped, analog still runs
      rdc(IDX_STATUS, 8'h04);
   endtask
   task s_out;
      int p, k;
      wr(IDX_OUT_DIV, 8'h83);
      for (int s = 0; s < 6; s++) begin
         wr(IDX_OUT_SRC, 8'(s));
         per(3, 1000, p, k);
         // source bit s rises every 2 << s cycles, ratio three
         chk(p, 6 << s, "output period per source");
      end
      wr(IDX_OUT_SRC, 8'h00);
      wr(IDX_OUT_DIV, 8'h80);
      per(3, 1200, p, k);
      chk(p, 256, "output ratio zero");
      wr(IDX_OUT_SRC, 8'h06);
      per(3, 600, p, k);
      chk(k, 0, "reserved source ran");
      wr(IDX_OUT_SRC, 8'h00);
      wr(IDX_OUT_DIV, 8'h00);
      repeat (300) @(posedge core_clk);
      chk({31'h0, oclk}, 32'h0, "disabled output high");
      per(3, 600, p, k);
      chk(k, 0, "disabled output rose");
   endtask
   initial begin
      repeat (5) @(posedge core_clk);
      reset <= 1'b0;
      s_resets;
      s_masks;
      s_stage;
      s_bclk;
      s_out;
      report_and_stop;
   end
endmodule
